// file: cbc_ctrl.sv
// Message buffers, error counters and prescaler of the CAN controller
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module cbc_ctrl
  import cbc_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              rx_done_i,
  input  wire logic [ID_W-1:0]   rx_id_i,
  input  wire logic [63:0]       rx_data_i,
  input  wire logic              rx_crc_err_i,
  input  wire logic              rx_stuff_err_i,
  input  wire logic              rx_inv_err_i,
  input  wire logic              wake_bus_i,
  input  wire logic              wake_sleep_i,
  input  wire logic              bus_idle_i,
  input  wire logic              tx_ok_i,
  input  wire logic              tx_lost_arb_i,
  input  wire logic              tx_ack_err_i,
  input  wire logic              tx_form_err_i,
  input  wire logic              tx_bit_err_i,
  input  wire logic [2:0]        tx_rd_addr_i,
  output logic                   tx_start_o,
  output logic      [1:0]        tx_buf_sel_o,
  output logic      [DATA_W-1:0] tx_rd_data_o,
  output logic                   ack_enable_o,
  output logic                   module_clock_select_o,
  output logic                   tq_tick_o,
  output logic                   bit_tick_o,
  output logic                   irq_o
);
  logic [DATA_W-1:0] intf_r, inte_r, bitcfg_r, rd_mux;
  logic [5:0]        baud_prescaler_r;
  logic              cks_r, abort_all_bit_r;
  logic [2:0]        rxctrl_r;
  logic [DATA_W-1:0] filt_r [8];
  logic [DATA_W-1:0] txm_r [NTX][NTXW];
  logic [ID_W-1:0]   rxid_r [NRX];
  logic [63:0]       rxd_r [NRX];
  logic [1:0]        tx_priority_field_r [NTX];
  logic [NTX-1:0]    tx_req_r, tx_abt_r, tx_larb_r, tx_err_r, abort_pend_r;
  logic [7:0]        rx_error_counter_r;
  logic [8:0]        tx_err_cnt_r;
  cbc_tx_state_t     tx_state_r;
  logic [1:0]        act_r;
  logic [6:0]        presc_r;
  logic [4:0]        bitq_r;
  logic [DATA_W-1:0] intf_set, intf_nxt;
  logic [ID_W-1:0]   mask0, mask1, filt0, filt1;
  logic              acc0, acc1, ld0, ld1, ovr0, ovr1;
  logic              rx_err, tx_err, busoff;
  logic              wr_tx, tx_fin;
  logic [1:0]        wr_b, rd_b, pick;
  logic              pick_ok;
  logic [2:0]        wsel;
  logic [4:0]        bit_len;

  assign wr_tx = reg_wr_i && reg_addr_i[5:3] >= G_TX0
                 && reg_addr_i[5:3] < G_RX0 && wr_b < 2'(NTX);
  assign wr_b  = 2'(reg_addr_i[5:3] - G_TX0);
  assign rd_b  = 2'(reg_addr_i[5:3] - G_TX0);
  assign wsel  = reg_addr_i[2:0];

  // Acceptance: identifier bit compared only where its mask bit is one
  assign mask0 = {filt_r[1][12:0], filt_r[0]};
  assign mask1 = {filt_r[3][12:0], filt_r[2]};
  assign filt0 = {filt_r[5][12:0], filt_r[4]};
  assign filt1 = {filt_r[7][12:0], filt_r[6]};
  assign acc0  = ((rx_id_i ^ filt0) & mask0) == '0;
  assign acc1  = ((rx_id_i ^ filt1) & mask1) == '0;

  // Target selection and overrun, buffer 0 takes precedence
  always_comb
  begin
    ld0  = 1'b0;
    ld1  = 1'b0;
    ovr0 = 1'b0;
    ovr1 = 1'b0;
    if (rx_done_i && acc0)
    begin
      if (!rxctrl_r[B_FULL0])
        ld0 = 1'b1;
      else if (rxctrl_r[B_DOUBLE_BUFFER_ENABLE] && !rxctrl_r[B_FULL1])
        ld1 = 1'b1;
      else if (rxctrl_r[B_DOUBLE_BUFFER_ENABLE])
        ovr1 = 1'b1;
      else
        ovr0 = 1'b1;
    end
    else if (rx_done_i && acc1)
    begin
      if (!rxctrl_r[B_FULL1])
        ld1 = 1'b1;
      else
        ovr1 = 1'b1;
    end
  end

  assign rx_err = rx_crc_err_i || rx_stuff_err_i || rx_inv_err_i;
  assign tx_err = tx_ack_err_i || tx_form_err_i || tx_bit_err_i;
  assign busoff = tx_err_cnt_r > TX_BO;
  assign tx_fin = tx_state_r == TX_SEND
                  && (tx_ok_i || tx_lost_arb_i || tx_err);

  // Hardware-set interrupt flags
  always_comb
  begin
    intf_set = '0;
    intf_set[B_RX0IF]  = ld0;
    intf_set[B_RX1IF]  = ld1;
    intf_set[B_RX0OVR] = ovr0;
    intf_set[B_RX1OVR] = ovr1;
    intf_set[B_WAKIF]  = wake_bus_i || wake_sleep_i;
    intf_set[B_INVALID_MESSAGE_FLAG]  = rx_err;
    intf_set[B_RX_WARNING_FLAG]  = rx_error_counter_r >= RX_WARN;
    intf_set[B_RX_ERROR_PASSIVE_FLAG]   = rx_error_counter_r > RX_EP;
    intf_set[B_TX_WARNING_FLAG]  = tx_err_cnt_r > TX_WARN;
    intf_set[B_TX_ERROR_PASSIVE_FLAG]   = tx_err_cnt_r > TX_EP;
    intf_set[B_BUS_OFF_FLAG]   = busoff;
    if (tx_fin && tx_ok_i)
      intf_set[B_TX0IF + int'(act_r)] = 1'b1;
    intf_set[B_ERROR_SUMMARY_FLAG]  = ovr0 || ovr1 || rx_err || tx_fin && tx_err
                         || intf_set[B_RX_WARNING_FLAG] || intf_set[B_TX_WARNING_FLAG]
                         || intf_set[B_RX_ERROR_PASSIVE_FLAG] || intf_set[B_TX_ERROR_PASSIVE_FLAG]
                         || busoff;
  end

  // Software clears by writing zero; a coincident set wins
  assign intf_nxt = ((reg_wr_i && reg_addr_i == A_INTF)
                     ? (intf_r & reg_wdata_i) : intf_r) | intf_set;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      intf_r <= '0;
    else
      intf_r <= intf_nxt;
  end

  assign irq_o = |(intf_r & inte_r);

  // Plain configuration registers
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      inte_r           <= '0;
      bitcfg_r         <= '0;
      baud_prescaler_r <= '0;
      cks_r            <= 1'b0;
      for (int i = 0; i < 8; i++)
        filt_r[i] <= '0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == A_INTE)
        inte_r <= reg_wdata_i;
      if (reg_addr_i == A_BITCFG)
        bitcfg_r <= reg_wdata_i;
      if (reg_addr_i == A_BAUD)
        baud_prescaler_r <= reg_wdata_i[5:0];
      if (reg_addr_i == A_MODCTRL)
        cks_r <= reg_wdata_i[B_CKS];
      if (reg_addr_i[5:3] == G_FILT)
        filt_r[wsel] <= reg_wdata_i;
    end
  end

  // Receive buffers and full bits
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rxctrl_r <= '0;
      for (int i = 0; i < NRX; i++)
      begin
        rxid_r[i] <= '0;
        rxd_r[i]  <= '0;
      end
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == A_RXCTRL)
        rxctrl_r <= {reg_wdata_i[B_DOUBLE_BUFFER_ENABLE],
                     rxctrl_r[B_FULL1] & reg_wdata_i[B_FULL1] | ld1,
                     rxctrl_r[B_FULL0] & reg_wdata_i[B_FULL0] | ld0};
      else
        rxctrl_r <= rxctrl_r | {1'b0, ld1, ld0};
      if (ld0)
      begin
        rxid_r[0] <= rx_id_i;
        rxd_r[0]  <= rx_data_i;
      end
      if (ld1)
      begin
        rxid_r[1] <= rx_id_i;
        rxd_r[1]  <= rx_data_i;
      end
    end
  end

  // Error counters, saturating
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_error_counter_r <= '0;
      tx_err_cnt_r       <= '0;
    end
    else
    begin
      if (rx_err && rx_error_counter_r != RX_MAX)
        rx_error_counter_r <= rx_error_counter_r + 8'h01;
      if (tx_fin && tx_err && !busoff)
        tx_err_cnt_r <= tx_err_cnt_r + 9'h001;
    end
  end

  // Highest priority pending buffer, lowest index on a tie
  always_comb
  begin
    pick    = 2'h0;
    pick_ok = 1'b0;
    for (int i = NTX - 1; i >= 0; i--)
      if (tx_req_r[i] && !abort_pend_r[i] && (!pick_ok
          || tx_priority_field_r[i] >= tx_priority_field_r[pick]))
      begin
        pick    = 2'(i);
        pick_ok = 1'b1;
      end
  end

  // Transmit scheduling; no start while bus-off
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_state_r <= TX_IDLE;
      act_r      <= 2'h0;
      tx_start_o <= 1'b0;
    end
    else
    begin
      tx_start_o <= 1'b0;
      unique case (tx_state_r)
        TX_IDLE:
          if (bus_idle_i && pick_ok && !busoff && !abort_all_bit_r)
          begin
            tx_state_r <= TX_SEND;
            act_r      <= pick;
            tx_start_o <= 1'b1;
          end
        TX_SEND:
          if (tx_fin)
            tx_state_r <= TX_IDLE;
      endcase
    end
  end

  assign tx_buf_sel_o = act_r;
  assign ack_enable_o = !busoff;

  // Abort-all request, held until the active buffer settles
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      abort_all_bit_r <= 1'b0;
    else if (reg_wr_i && reg_addr_i == A_MODCTRL && reg_wdata_i[B_ABORT_ALL_BIT])
      abort_all_bit_r <= 1'b1;
    else if (tx_state_r == TX_IDLE || tx_fin)
      abort_all_bit_r <= 1'b0;
  end

  // Per-buffer transmit control and data words
  for (genvar b = 0; b < NTX; b++)
  begin : g_tx
    logic wr_ctl, busy, drop;
    assign wr_ctl = wr_tx && wr_b == 2'(b) && wsel == 3'h0;
    assign busy   = tx_state_r == TX_SEND && act_r == 2'(b);
    assign drop   = busy && tx_fin && !tx_ok_i
                    && (abort_pend_r[b] || abort_all_bit_r);

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        tx_priority_field_r[b] <= 2'h0;
        tx_req_r[b]     <= 1'b0;
        tx_abt_r[b]     <= 1'b0;
        tx_larb_r[b]    <= 1'b0;
        tx_err_r[b]     <= 1'b0;
        abort_pend_r[b] <= 1'b0;
        for (int w = 0; w < NTXW; w++)
          txm_r[b][w] <= '0;
      end
      else
      begin
        if (wr_tx && wr_b == 2'(b) && wsel != 3'h0)
          txm_r[b][wsel - 3'h1] <= reg_wdata_i;
        if (busy && tx_fin)
        begin
          tx_err_r[b]  <= tx_err;
          tx_larb_r[b] <= tx_lost_arb_i;
          if (tx_ok_i)
            tx_req_r[b] <= 1'b0;
        end
        if (drop)
        begin
          tx_req_r[b]     <= 1'b0;
          tx_abt_r[b]     <= 1'b1;
          abort_pend_r[b] <= 1'b0;
        end
        else if (busy && tx_fin)
          abort_pend_r[b] <= 1'b0;
        if (abort_all_bit_r && !busy && tx_req_r[b])
        begin
          tx_req_r[b] <= 1'b0;
          tx_abt_r[b] <= 1'b1;
        end
        if (wr_ctl)
        begin
          tx_priority_field_r[b] <= reg_wdata_i[1:0];
          if (reg_wdata_i[B_TX_REQUEST_BIT])
          begin
            tx_req_r[b]  <= 1'b1;
            tx_abt_r[b]  <= 1'b0;
            tx_larb_r[b] <= 1'b0;
            tx_err_r[b]  <= 1'b0;
          end
          else if (tx_req_r[b] && busy)
            abort_pend_r[b] <= 1'b1;
          else if (tx_req_r[b])
          begin
            tx_req_r[b] <= 1'b0;
            tx_abt_r[b] <= 1'b1;
          end
        end
      end
    end
  end

  // Word read port for the frame serialiser
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      tx_rd_data_o <= '0;
    else if (tx_rd_addr_i < 3'(NTXW))
      tx_rd_data_o <= txm_r[act_r][tx_rd_addr_i];
    else
      tx_rd_data_o <= '0;
  end

  // Quantum: 2 * (prescaler + 1) module clocks
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      presc_r <= '0;
    else if (presc_r >= {baud_prescaler_r, 1'b1})
      presc_r <= '0;
    else
      presc_r <= presc_r + 7'h01;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      tq_tick_o <= 1'b0;
    else
      tq_tick_o <= presc_r >= {baud_prescaler_r, 1'b1};
  end

  assign module_clock_select_o = cks_r;

  // Nominal bit: sync + prop + phase1 + phase2, clamped to 8..25
  always_comb
  begin
    bit_len = 5'h04 + 5'(bitcfg_r[2:0]) + 5'(bitcfg_r[5:3])
              + 5'(bitcfg_r[10:8]);
    if (bit_len < TQ_MIN)
      bit_len = TQ_MIN;
    else if (bit_len > TQ_MAX)
      bit_len = TQ_MAX;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      bitq_r     <= '0;
      bit_tick_o <= 1'b0;
    end
    else
    begin
      bit_tick_o <= 1'b0;
      if (tq_tick_o)
      begin
        if (bitq_r >= bit_len - 5'h01)
        begin
          bitq_r     <= '0;
          bit_tick_o <= 1'b1;
        end
        else
          bitq_r <= bitq_r + 5'h01;
      end
    end
  end

  // Register read decode; unmapped words read zero
  always_comb
  begin
    rd_mux = '0;
    unique case (reg_addr_i[5:3])
      3'h0:
        unique case (reg_addr_i)
          A_MODCTRL: rd_mux = DATA_W'({abort_all_bit_r, cks_r, 11'h000});
          A_BITCFG:  rd_mux = bitcfg_r;
          A_INTF:    rd_mux = intf_r;
          A_INTE:    rd_mux = inte_r;
          A_RXCTRL:  rd_mux = DATA_W'(rxctrl_r);
          A_RXCNT:   rd_mux = DATA_W'(rx_error_counter_r);
          A_TXCNT:   rd_mux = DATA_W'(tx_err_cnt_r);
          A_BAUD:    rd_mux = DATA_W'(baud_prescaler_r);
          default:   rd_mux = '0;
        endcase
      G_FILT: rd_mux = filt_r[wsel];
      G_RX0, G_RX1:
        unique case (wsel)
          3'h0: rd_mux = rxid_r[reg_addr_i[3]][15:0];
          3'h1: rd_mux = DATA_W'(rxid_r[reg_addr_i[3]][ID_W-1:16]);
          3'h2: rd_mux = rxd_r[reg_addr_i[3]][15:0];
          3'h3: rd_mux = rxd_r[reg_addr_i[3]][31:16];
          3'h4: rd_mux = rxd_r[reg_addr_i[3]][47:32];
          3'h5: rd_mux = rxd_r[reg_addr_i[3]][63:48];
          default: rd_mux = '0;
        endcase
      default:
        // Group past the last transmit buffer is unmapped
        if (rd_b >= 2'(NTX))
          rd_mux = '0;
        else if (wsel == 3'h0)
          rd_mux = DATA_W'({tx_abt_r[rd_b], tx_larb_r[rd_b],
                            tx_err_r[rd_b], tx_req_r[rd_b], 1'b0,
                            tx_priority_field_r[rd_b]});
        else
          rd_mux = txm_r[rd_b][wsel - 3'h1];
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= '0;
    else if (reg_rd_i)
      reg_rdata_o <= rd_mux;
    else
      reg_rdata_o <= '0;
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  rx_overrun_flag_a: assert property (ovr0 |=> intf_r[B_RX0OVR]
    && intf_r[B_ERROR_SUMMARY_FLAG]) else $error("overrun flags not set");
  dbuf_divert_a: assert property (rx_done_i && acc0
    && rxctrl_r[B_DOUBLE_BUFFER_ENABLE] && rxctrl_r[B_FULL0] && !rxctrl_r[B_FULL1]
    |=> rxctrl_r[B_FULL1] && !intf_r[B_RX0OVR] || $past(intf_r[B_RX0OVR]))
    else $error("double buffer divert failed");
  rx_count_a: assert property (rx_err && rx_error_counter_r < RX_MAX
    |=> rx_error_counter_r == $past(rx_error_counter_r) + 8'h01)
    else $error("receive counter not incremented");
  rx_passive_a: assert property (rx_error_counter_r > RX_EP
    |=> intf_r[B_RX_ERROR_PASSIVE_FLAG]) else $error("receive passive not flagged");
  tx_clear_a: assert property (wr_tx && wsel == 3'h0
    && reg_wdata_i[B_TX_REQUEST_BIT] |=> tx_req_r[$past(wr_b)]
    && !tx_abt_r[$past(wr_b)]) else $error("request flags not cleared");
  tx_success_a: assert property (tx_fin && tx_ok_i
    |=> !tx_req_r[$past(act_r)] && intf_r[B_TX0IF + int'($past(act_r))])
    else $error("success not handled");
  busoff_start_a: assert property (busoff |-> !tx_start_o ##1 !tx_start_o)
    else $error("start while bus-off");
  tq_period_a: assert property (tq_tick_o && baud_prescaler_r == 6'h00
    ##1 baud_prescaler_r == 6'h00 |-> !tq_tick_o ##1 tq_tick_o)
    else $error("quantum period wrong");
  tx_warn_a: assert property (tx_err_cnt_r > TX_WARN
    |=> intf_r[B_TX_WARNING_FLAG] && intf_r[B_ERROR_SUMMARY_FLAG]) else $error("tx warning missing");
endmodule

// file: cbc_ctrl_tb.sv
// Self-checking bench for the CAN buffer and error-count block
`timescale 1ns/1ps
module cbc_ctrl_tb
  import cbc_pkg::*;
;
  logic              mclk_i, reset_n_i, wr, rd, idle_en, tx_start;
  logic              ack_en, cks, irq, idle;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, txd;
  logic [ID_W-1:0]   rx_id;
  logic [5:0]        pls;
  logic [1:0]        mode, sel, ticks;
  logic [3:0]        dly;
  logic [4:0]        outc;
  logic [2:0]        rda;
  int                failures, total_checks, starts, done, i, s;
  // Expected start order after the late priority change
  int                s_ord[3] = '{2, 0, 1};

  cbc_ctrl dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .rx_done_i(pls[0]), .rx_id_i(rx_id), .rx_data_i(64'hA5A5_5A5A_0F0F_F0F0),
    .rx_crc_err_i(pls[1]), .rx_stuff_err_i(pls[2]), .rx_inv_err_i(pls[3]),
    .wake_bus_i(pls[4]), .wake_sleep_i(pls[5]), .bus_idle_i(idle),
    .tx_ok_i(outc[0]), .tx_lost_arb_i(outc[1]), .tx_ack_err_i(outc[2]),
    .tx_form_err_i(outc[3]), .tx_bit_err_i(outc[4]), .tx_rd_addr_i(rda),
    .tx_start_o(tx_start), .tx_buf_sel_o(sel), .tx_rd_data_o(txd),
    .ack_enable_o(ack_en), .module_clock_select_o(cks),
    .tq_tick_o(ticks[0]), .bit_tick_o(ticks[1]), .irq_o(irq));

  cbc_node_model node (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .tx_start_i(tx_start), .idle_en_i(idle_en), .mode_i(mode),
    .delay_i(dly), .bus_idle_o(idle), .outcome_o(outc), .rd_addr_o(rda),
    .starts_o(starts), .done_o(done));

  task automatic complete_run();
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] m, e);
    @(posedge mclk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    cmp(rdata & m, e);
  endtask

  task automatic pulse(input int b);
    @(posedge mclk_i);
    pls[b] <= 1'b1;
    @(posedge mclk_i);
    pls[b] <= 1'b0;
  endtask

  task automatic rx_msg(input logic [ID_W-1:0] id);
    rx_id <= id;
    pulse(0);
  endtask

  task automatic wait_for(ref int c, input int tgt);
    for (int n = 0; n < 500 && c < tgt; n++)
      @(posedge mclk_i);
    if (c < tgt)
    begin
      failures++;
      complete_run();
    end
  endtask

  // One gated frame attempt: open the bus until a start, then close it
  task automatic attempt();
    int t;
    t = starts;
    idle_en <= 1'b1;
    wait_for(starts, t + 1);
    idle_en <= 1'b0;
    wait_for(done, t + 1);
  endtask

  // Skip to a tick, then count clocks to the next one
  task automatic period(input int w, input int e);
    int c;
    repeat (2)
    begin
      c = 0;
      do
      begin
        @(posedge mclk_i);
        c++;
      end
      while (c < 600 && ticks[w] !== 1'b1);
    end
    cmp(c, e);
  endtask

  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  initial
  begin
    reset_n_i = 1'b0;
    {wr, rd, idle_en, pls, mode, addr, wdata, rx_id} = '0;
    dly = 4'h7;
    failures = 0;
    total_checks = 0;
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd_chk(A_INTF, 16'hFFFF, 16'h0000);
    cmp(ack_en, 1'b1);
    // Mask 0 all zero accepts any id; mask 1 demands an exact match
    wr_reg(6'h08, 16'h0000);
    wr_reg(6'h09, 16'h0000);
    wr_reg(6'h0C, 16'h5555);
    wr_reg(6'h0D, 16'h1555);
    wr_reg(6'h0A, 16'hFFFF);
    wr_reg(6'h0B, 16'h1FFF);
    wr_reg(6'h0E, 16'h0FFF);
    wr_reg(6'h0F, 16'h0000);
    wr_reg(A_INTE, 16'h0001);
    rx_msg(29'h0123);
    rd_chk(A_INTF, 16'hC023, 16'h0001);
    cmp(irq, 1'b1);
    rd_chk(6'h30, 16'hFFFF, 16'h0123);
    rd_chk(6'h32, 16'hFFFF, 16'hF0F0);
    rx_msg(29'h0456);
    rd_chk(A_INTF, 16'hC022, 16'h8020);
    rd_chk(6'h30, 16'hFFFF, 16'h0123);
    wr_reg(A_INTF, 16'h0000);
    wr_reg(A_RXCTRL, 16'h0004);
    rx_msg(29'h0123);
    rx_msg(29'h0456);
    rd_chk(A_INTF, 16'hC023, 16'h0003);
    rd_chk(6'h38, 16'hFFFF, 16'h0456);
    rx_msg(29'h0789);
    rd_chk(A_INTF, 16'hC020, 16'h4020);
    // Mask 0 now compares low bits: id misses buffer 0, hits buffer 1
    wr_reg(6'h08, 16'hFFFF);
    wr_reg(A_RXCTRL, 16'h0001);
    rx_msg(29'h0FFF);
    rd_chk(6'h38, 16'hFFFF, 16'h0FFF);
    wr_reg(A_INTF, 16'h0000);
    wr_reg(A_INTE, 16'h0200);
    for (i = 0; i < 95; i++)
      pulse(1 + i % 3);
    rd_chk(A_RXCNT, 16'h00FF, 16'h005F);
    rd_chk(A_INTF, 16'h0280, 16'h0080);
    cmp(irq, 1'b0);
    pulse(1);
    rd_chk(A_INTF, 16'h0A20, 16'h0220);
    cmp(irq, 1'b1);
    for (i = 0; i < 31; i++)
      pulse(2);
    rd_chk(A_INTF, 16'h0800, 16'h0000);
    pulse(3);
    rd_chk(A_INTF, 16'h0800, 16'h0800);
    for (i = 4; i < 6; i++)
    begin
      wr_reg(A_INTF, 16'h0000);
      pulse(i);
      rd_chk(A_INTF, 16'h0040, 16'h0040);
    end
    wr_reg(A_INTF, 16'h0000);
    wr_reg(A_INTE, 16'h001C);
    wr_reg(6'h11, 16'hBEEF);
    rd_chk(6'h11, 16'hFFFF, 16'hBEEF);
    wr_reg(6'h10, 16'h0009);
    wr_reg(6'h18, 16'h000B);
    wr_reg(6'h20, 16'h000A);
    wr_reg(6'h18, 16'h0008);
    dly = 4'h0;
    foreach (s_ord[k])
    begin
      attempt();
      cmp(sel, s_ord[k]);
      rd_chk(A_INTF, 16'h0004 << s_ord[k], 16'h0004 << s_ord[k]);
    end
    rd_chk(6'h18, 16'h0008, 16'h0000);
    cmp(irq, 1'b1);
    dly = 4'h7;
    mode = 2'h1;
    wr_reg(A_INTF, 16'h0000);
    wr_reg(6'h10, 16'h0008);
    attempt();
    rd_chk(6'h10, 16'h0078, 16'h0028);
    cmp(txd, 16'hBEEF);
    rd_chk(A_INTF, 16'h0004, 16'h0000);
    wr_reg(6'h10, 16'h0000);
    rd_chk(6'h10, 16'h0048, 16'h0040);
    wr_reg(6'h10, 16'h0008);
    rd_chk(6'h10, 16'h0078, 16'h0008);
    wr_reg(A_MODCTRL, 16'h1000);
    rd_chk(6'h10, 16'h0048, 16'h0040);
    rd_chk(A_INTF, 16'h0004, 16'h0000);
    wr_reg(A_MODCTRL, 16'h0800);
    #1 cmp(cks, 1'b1);
    wr_reg(A_BAUD, 16'h0003);
    wr_reg(A_BITCFG, 16'h0000);
    period(0, 8);
    period(1, 64);
    wr_reg(A_BITCFG, 16'h073F);
    period(1, 200);
    mode = 2'h2;
    wr_reg(A_INTF, 16'h0000);
    wr_reg(A_INTE, 16'h0400);
    wr_reg(6'h10, 16'h0008);
    for (i = 1; i < 257; i++)
    begin
      attempt();
      rd_chk(A_TXCNT, 16'h01FF, i[15:0]);
      rd_chk(A_INTF, 16'h3420, {2'b00, i > 255, i > 127, 1'b0, i > 96,
                                 10'h020});
      cmp(irq, i > 96);
    end
    rd_chk(6'h10, 16'h0018, 16'h0018);
    cmp(ack_en, 1'b0);
    s = starts;
    idle_en <= 1'b1;
    repeat (30) @(posedge mclk_i);
    cmp(starts, s);
    complete_run();
  end
endmodule

// file: cbc_node_model.sv
// Behavioural neighbour node: gates bus idle, answers each frame start
`timescale 1ns/1ps
module cbc_node_model
(
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  input  wire logic       tx_start_i,
  input  wire logic       idle_en_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [3:0] delay_i,
  output logic            bus_idle_o,
  output logic [4:0]      outcome_o,
  output logic [2:0]      rd_addr_o,
  output int              starts_o,
  output int              done_o
);
  logic       busy_r;
  logic [3:0] cnt_r;

  // Bus is never free while our own frame is in flight
  assign bus_idle_o = idle_en_i & ~busy_r;
  assign rd_addr_o  = cnt_r[2:0];

  always_ff @(posedge mclk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      busy_r   <= 1'b0;
      cnt_r    <= 4'h0;
      starts_o <= 0;
      done_o   <= 0;
    end
    else if (tx_start_i)
    begin
      busy_r   <= 1'b1;
      cnt_r    <= delay_i;
      starts_o <= starts_o + 1;
    end
    else if (busy_r && cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
    else if (busy_r)
    begin
      busy_r <= 1'b0;
      done_o <= done_o + 1;
    end

  // One outcome pulse per attempt: ok, lost, a rotating error kind, or a fixed form error in mode 3
  always_comb
  begin
    outcome_o = 5'h00;
    if (busy_r && cnt_r == 4'h0)
      outcome_o = (mode_i == 2'h2) ? 5'(5'h04 << (done_o % 3))
                                   : 5'(5'h01 << mode_i);
  end
endmodule

// file: cbc_pkg.sv
// Constants for the CAN buffer, error-count and prescaler control block
package cbc_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int ID_W   = 29;
  localparam int NTX    = 3;
  localparam int NTXW   = 7;
  localparam int NRX    = 2;

  localparam logic [5:0] A_MODCTRL = 6'h00;
  localparam logic [5:0] A_BITCFG  = 6'h01;
  localparam logic [5:0] A_INTF    = 6'h02;
  localparam logic [5:0] A_INTE    = 6'h03;
  localparam logic [5:0] A_RXCTRL  = 6'h04;
  localparam logic [5:0] A_RXCNT   = 6'h05;
  localparam logic [5:0] A_TXCNT   = 6'h06;
  localparam logic [5:0] A_BAUD    = 6'h07;
  localparam logic [2:0] G_FILT    = 3'h1;
  localparam logic [2:0] G_TX0     = 3'h2;
  localparam logic [2:0] G_RX0     = 3'h6;
  localparam logic [2:0] G_RX1     = 3'h7;

  localparam int B_CKS    = 11;
  localparam int B_ABORT_ALL_BIT   = 12;
  localparam int B_RX0IF  = 0;
  localparam int B_RX1IF  = 1;
  localparam int B_TX0IF  = 2;
  localparam int B_ERROR_SUMMARY_FLAG  = 5;
  localparam int B_WAKIF  = 6;
  localparam int B_INVALID_MESSAGE_FLAG  = 7;
  localparam int B_RX_WARNING_FLAG  = 9;
  localparam int B_TX_WARNING_FLAG  = 10;
  localparam int B_RX_ERROR_PASSIVE_FLAG   = 11;
  localparam int B_TX_ERROR_PASSIVE_FLAG   = 12;
  localparam int B_BUS_OFF_FLAG   = 13;
  localparam int B_RX1OVR = 14;
  localparam int B_RX0OVR = 15;
  localparam int B_TX_REQUEST_BIT  = 3;
  localparam int B_TX_ERROR_FLAG  = 4;
  localparam int B_TX_LOST_ARBITRATION_FLAG = 5;
  localparam int B_TX_ABORTED_FLAG  = 6;
  localparam int B_FULL0  = 0;
  localparam int B_FULL1  = 1;
  localparam int B_DOUBLE_BUFFER_ENABLE   = 2;

  localparam logic [7:0] RX_WARN = 8'h60;
  localparam logic [7:0] RX_EP   = 8'h7F;
  localparam logic [7:0] RX_MAX  = 8'hFF;
  localparam logic [8:0] TX_WARN = 9'h060;
  localparam logic [8:0] TX_EP   = 9'h07F;
  localparam logic [8:0] TX_BO   = 9'h0FF;
  localparam logic [4:0] TQ_MIN  = 5'h08;
  localparam logic [4:0] TQ_MAX  = 5'h19;

  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} cbc_tx_state_t;
endpackage
